// File: amrt_mem_model.sv
`timescale 1ns/1ps
module amrt_mem_model (
  // controller side
  input wire logic clk,
  input wire logic [23:0] ext_addr,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  // byte lane back
  output logic [7:0] ext_data_in
);
  // no pull on the lane: a released bus shows a moving pattern, never the last byte
  logic [7:0] junk_reg = 8'h00;
  always_ff @(posedge clk) junk_reg <= ~junk_reg + 8'h5b;
  assign ext_data_in = (!read_strobe_n || !(&chip_select_n)) ?
    (ext_addr[7:0] ^ ext_addr[15:8] ^ ext_addr[23:16]) : junk_reg;
endmodule : amrt_mem_model

// File: amrt_pkg.sv
package amrt_pkg;
  localparam int unsigned AMRT_NUM_CS = 4;
  localparam int unsigned AMRT_ADDR_W = 24;
  localparam int unsigned AMRT_DATA_W = 8;
  localparam int unsigned AMRT_SETUP_W = 6;
  localparam int unsigned AMRT_PULSE_W = 7;
  localparam int unsigned AMRT_CYCLE_W = 9;
  localparam int unsigned AMRT_CNT_W = 10;
  // system address: chip select index sits just above the 16 Mbyte window
  localparam int unsigned AMRT_CS_LSB = 24;
  localparam int unsigned AMRT_SYS_ADDR_W = 26;
  // reset values of the per chip select timing codes, read mode and flash assignment
  localparam logic [5:0] AMRT_SETUP_RST = 6'h01;
  localparam logic [6:0] AMRT_PULSE_RST = 7'h01;
  localparam logic [8:0] AMRT_CYCLE_RST = 9'h003;
  localparam logic AMRT_READ_MODE_RST = 1'b1;
  localparam logic [3:0] AMRT_FLASH_ASSIGN_RST = 4'h0;
  // code field positions
  localparam int unsigned AMRT_SETUP_HI_BIT = 5;
  localparam int unsigned AMRT_PULSE_HI_BIT = 6;
  localparam int unsigned AMRT_CYCLE_HI_LSB = 7;
  typedef enum logic [1:0] {
    AMRT_IDLE,
    AMRT_RUN,
    AMRT_DONE
  } amrt_state_e;
endpackage : amrt_pkg

// File: amrt_read_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - 24-bit address bus, 16 Mbyte window each.
// - single 8-bit data lane.
// - per chip select NAND assignment bit.
// - NAND chip select routes strobes to flash.
// - flash enables drop when address leaves window.
// - cycle starts by driving the address.
// - strobe: setup, pulse low, then hold high.
// - chip select has own setup and pulse.
// - hold derived from total cycle length.
// - timings per chip select, clock cycles.
// - zero setup/hold keeps strobes low back-to-back.
// - mode bit picks capture signal, no compare.
// - mode one: capture at strobe rising edge.
// - mode zero: capture at chip select rise.
// - setup and pulse codes decoded with weights.
// - cycle code decoded with weight 256.
// - mode defaults to strobe-controlled after reset.
module amrt_read_ctrl
  import amrt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration, flattened per chip select (index i at [i*w +: w])
  input wire logic [23:0] read_strobe_setup,
  input wire logic [23:0] select_read_setup,
  input wire logic [27:0] read_strobe_pulse,
  input wire logic [27:0] select_read_pulse,
  input wire logic [35:0] read_total_cycle,
  input wire logic [3:0] read_mode_cfg,
  input wire logic [3:0] flash_cs_assign,
  input wire logic cfg_load,
  // read request
  input wire logic req_valid,
  input wire logic [25:0] req_addr,
  output logic req_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // write strobe from write path
  input wire logic write_strobe_n,
  // external pins
  output logic [23:0] ext_addr,
  input wire logic [7:0] ext_data_in,
  output logic [7:0] ext_data_out,
  output logic ext_data_oe,
  output logic [3:0] chip_select_n,
  output logic read_strobe_n,
  output logic flash_out_enable_n,
  output logic flash_write_enable_n,
  // status
  output logic [3:0] read_mode_status,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] dec_setup(input logic [5:0] c);
    dec_setup = {c[AMRT_SETUP_HI_BIT], 9'h000} >> 2;
    dec_setup = dec_setup + {5'h00, c[4:0]};
  endfunction : dec_setup

  function automatic logic [9:0] dec_pulse(input logic [6:0] c);
    dec_pulse = {1'b0, c[AMRT_PULSE_HI_BIT], 8'h00} + {4'h0, c[5:0]};
  endfunction : dec_pulse

  function automatic logic [9:0] dec_cycle(input logic [8:0] c);
    dec_cycle = {c[8:AMRT_CYCLE_HI_LSB], 8'h00} + {3'h0, c[6:0]};
  endfunction : dec_cycle

  // per chip select code fields, index i at [i*w +: w]
  function automatic logic [5:0] pick_setup(input logic [23:0] v, input logic [1:0] i);
    pick_setup = v[i*6 +: 6];
  endfunction : pick_setup

  function automatic logic [6:0] pick_pulse(input logic [27:0] v, input logic [1:0] i);
    pick_pulse = v[i*7 +: 7];
  endfunction : pick_pulse

  function automatic logic [8:0] pick_cycle(input logic [35:0] v, input logic [1:0] i);
    pick_cycle = v[i*9 +: 9];
  endfunction : pick_cycle

  // low window of a strobe; the hold is whatever is left of the total cycle
  function automatic logic in_window(input logic [9:0] t, input logic [9:0] on,
                                     input logic [9:0] off);
    in_window = (t >= on) && (t < off);
  endfunction : in_window

  ////////////////////////////////////////////////////////////////////////////
  // latched per chip select configuration
  logic [23:0] rs_setup_reg, rs_setup_next;
  logic [23:0] cs_setup_reg, cs_setup_next;
  logic [27:0] rs_pulse_reg, rs_pulse_next;
  logic [27:0] cs_pulse_reg, cs_pulse_next;
  logic [35:0] cycle_reg, cycle_next;
  logic [3:0] mode_reg, mode_next;
  logic [3:0] assign_reg, assign_next;

  always_comb begin
    rs_setup_next = rs_setup_reg;
    cs_setup_next = cs_setup_reg;
    rs_pulse_next = rs_pulse_reg;
    cs_pulse_next = cs_pulse_reg;
    cycle_next = cycle_reg;
    mode_next = mode_reg;
    assign_next = assign_reg;
    if (cfg_load) begin
      rs_setup_next = read_strobe_setup;
      cs_setup_next = select_read_setup;
      rs_pulse_next = read_strobe_pulse;
      cs_pulse_next = select_read_pulse;
      cycle_next = read_total_cycle;
      mode_next = read_mode_cfg;
      assign_next = flash_cs_assign;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_setup_reg <= {AMRT_NUM_CS{AMRT_SETUP_RST}};
      cs_setup_reg <= {AMRT_NUM_CS{AMRT_SETUP_RST}};
      rs_pulse_reg <= {AMRT_NUM_CS{AMRT_PULSE_RST}};
      cs_pulse_reg <= {AMRT_NUM_CS{AMRT_PULSE_RST}};
      cycle_reg <= {AMRT_NUM_CS{AMRT_CYCLE_RST}};
      mode_reg <= {AMRT_NUM_CS{AMRT_READ_MODE_RST}};
      assign_reg <= AMRT_FLASH_ASSIGN_RST;
    end else begin
      rs_setup_reg <= rs_setup_next;
      cs_setup_reg <= cs_setup_next;
      rs_pulse_reg <= rs_pulse_next;
      cs_pulse_reg <= cs_pulse_next;
      cycle_reg <= cycle_next;
      mode_reg <= mode_next;
      assign_reg <= assign_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  // the running access uses timings frozen at its take, so a cfg_load mid cycle
  // only retimes the next access; the flash assignment applies at once
  amrt_state_e state_reg, state_next;
  logic [9:0] cnt_reg, cnt_next;
  logic [1:0] cs_idx_reg, cs_idx_next;
  logic [23:0] addr_reg, addr_next;
  logic [9:0] rs_on_reg, rs_on_next;
  logic [9:0] rs_off_reg, rs_off_next;
  logic [9:0] cs_on_reg, cs_on_next;
  logic [9:0] cs_off_reg, cs_off_next;
  logic [9:0] total_reg, total_next;
  logic mode_cur_reg, mode_cur_next;
  logic active_reg, active_next;
  logic rs_n_reg, rs_n_next;
  logic [3:0] cs_n_reg, cs_n_next;
  logic [1:0] rq_idx;
  logic [9:0] cnt_inc;
  logic last;
  logic sample;
  logic take;

  assign rq_idx = req_addr[AMRT_CS_LSB +: 2];
  assign cnt_inc = cnt_reg + 10'h001;
  assign last = (cnt_inc >= total_reg);
  // taking in the last cycle leaves no idle gap between back-to-back reads
  assign take = req_valid && (state_reg != AMRT_RUN || last);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cs_idx_next = cs_idx_reg;
    addr_next = addr_reg;
    rs_on_next = rs_on_reg;
    rs_off_next = rs_off_reg;
    cs_on_next = cs_on_reg;
    cs_off_next = cs_off_reg;
    total_next = total_reg;
    mode_cur_next = mode_cur_reg;
    active_next = active_reg;
    sample = 1'b0;
    unique case (state_reg)
      AMRT_IDLE, AMRT_DONE: begin
        state_next = AMRT_IDLE;
        active_next = 1'b0;
      end
      AMRT_RUN: begin
        cnt_next = cnt_inc;
        // capture on the edge raising the governing signal, no compare
        sample = mode_cur_reg ? (cnt_inc == rs_off_reg) : (cnt_inc == cs_off_reg);
        if (last) begin
          state_next = AMRT_DONE;
        end
      end
      default: state_next = AMRT_IDLE;
    endcase
    if (take) begin
      state_next = AMRT_RUN;
      cnt_next = 10'h000;
      active_next = 1'b1;
      cs_idx_next = rq_idx;
      addr_next = req_addr[AMRT_ADDR_W-1:0];
      rs_on_next = dec_setup(pick_setup(rs_setup_reg, rq_idx));
      rs_off_next = rs_on_next + dec_pulse(pick_pulse(rs_pulse_reg, rq_idx));
      cs_on_next = dec_setup(pick_setup(cs_setup_reg, rq_idx));
      cs_off_next = cs_on_next + dec_pulse(pick_pulse(cs_pulse_reg, rq_idx));
      total_next = dec_cycle(pick_cycle(cycle_reg, rq_idx));
      mode_cur_next = mode_reg[rq_idx];
    end
    // strobe levels for the next cycle; zero setup and hold keep them low across a
    // back-to-back cycle to the same memory
    rs_n_next = 1'b1;
    cs_n_next = 4'hf;
    if (active_next && state_next == AMRT_RUN) begin
      if (in_window(cnt_next, rs_on_next, rs_off_next)) begin
        rs_n_next = 1'b0;
      end
      if (in_window(cnt_next, cs_on_next, cs_off_next)) begin
        cs_n_next[cs_idx_next] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= AMRT_IDLE;
      cnt_reg <= 10'h000;
      cs_idx_reg <= 2'h0;
      addr_reg <= 24'h00_0000;
      rs_on_reg <= 10'h000;
      rs_off_reg <= 10'h000;
      cs_on_reg <= 10'h000;
      cs_off_reg <= 10'h000;
      total_reg <= 10'h000;
      mode_cur_reg <= AMRT_READ_MODE_RST;
      active_reg <= 1'b0;
      rs_n_reg <= 1'b1;
      cs_n_reg <= 4'hf;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cs_idx_reg <= cs_idx_next;
      addr_reg <= addr_next;
      rs_on_reg <= rs_on_next;
      rs_off_reg <= rs_off_next;
      cs_on_reg <= cs_on_next;
      cs_off_reg <= cs_off_next;
      total_reg <= total_next;
      mode_cur_reg <= mode_cur_next;
      active_reg <= active_next;
      rs_n_reg <= rs_n_next;
      cs_n_reg <= cs_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture; rd_data keeps the last byte until the next capture
  logic [7:0] data_reg, data_next;
  logic valid_reg, valid_next;

  always_comb begin
    data_next = data_reg;
    valid_next = 1'b0;
    if (sample) begin
      data_next = ext_data_in;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; a pulse code of zero gives an empty low window, undefined use
  // (software side) and A21/A22 pass through untouched
  assign req_ready = (state_reg != AMRT_RUN) || last;
  assign busy = (state_reg == AMRT_RUN);
  assign ext_addr = addr_reg;
  assign ext_data_out = 8'h00;
  assign ext_data_oe = 1'b0;
  assign chip_select_n = cs_n_reg;
  assign read_strobe_n = rs_n_reg;
  assign rd_valid = valid_reg;
  assign rd_data = data_reg;
  assign read_mode_status = mode_reg;
  // flash enables only while the assigned region is the one addressed; they fall
  // away with busy, so the next access to a plain region never sees them
  logic flash_sel;
  assign flash_sel = busy && assign_reg[cs_idx_reg];
  assign flash_out_enable_n = !flash_sel || rs_n_reg;
  assign flash_write_enable_n = !flash_sel || write_strobe_n;

endmodule : amrt_read_ctrl

// File: amrt_read_ctrl_monitor.sv
`timescale 1ns/1ps
module amrt_read_ctrl_monitor
  import amrt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // inputs watched
  input wire logic [3:0] flash_cs_assign,
  input wire logic cfg_load,
  input wire logic req_valid,
  input wire logic [25:0] req_addr,
  input wire logic write_strobe_n,
  // outputs watched
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic [23:0] ext_addr,
  input wire logic ext_data_oe,
  input wire logic [3:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic flash_out_enable_n,
  input wire logic flash_write_enable_n,
  input wire logic [3:0] read_mode_status,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // prev_reg names the select whose strobe edge lands while the next take updates sel_reg
  logic [1:0] sel_reg, sel_next, prev_reg;
  logic take_reg, take_next;
  // flash assignment as the design latches it, so a load mid cycle is not misread
  logic [3:0] asg_reg, asg_next;
  always_comb begin
    take_next = req_valid && req_ready;
    sel_next = take_next ? req_addr[25:24] : sel_reg;
    asg_next = cfg_load ? flash_cs_assign : asg_reg;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= 2'h0;
      prev_reg <= 2'h0;
      take_reg <= 1'b0;
      asg_reg <= AMRT_FLASH_ASSIGN_RST;
    end else begin
      sel_reg <= sel_next;
      prev_reg <= sel_reg;
      take_reg <= take_next;
      asg_reg <= asg_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_one_select: assert property ($onehot0(~chip_select_n))
    else $error("two chip selects low");
  a_flash_read_copy: assert property (
    flash_out_enable_n == (read_strobe_n || !busy || !asg_reg[sel_reg]))
    else $error("flash output enable wrong");
  a_flash_write_copy: assert property (
    flash_write_enable_n == (write_strobe_n || !busy || !asg_reg[sel_reg]))
    else $error("flash write enable wrong");
  a_data_released: assert property (!ext_data_oe)
    else $error("data bus driven during read");
  a_addr_steady: assert property (busy && !take_reg |-> $stable(ext_addr))
    else $error("address moved mid cycle");
  a_strobe_capture: assert property (
    $rose(read_strobe_n) && read_mode_status[prev_reg] |-> rd_valid)
    else $error("no capture at strobe rise");
  a_select_capture: assert property (
    $rose(chip_select_n[prev_reg]) && !read_mode_status[prev_reg] |-> rd_valid)
    else $error("no capture at select rise");
  a_strobe_in_cycle: assert property (
    !read_strobe_n || !(&chip_select_n) |-> busy)
    else $error("strobe low outside a cycle");
  c_select_mode: cover property (rd_valid && !read_mode_status[prev_reg]);
  c_flash_read: cover property (!flash_out_enable_n);
  c_long_low: cover property (!read_strobe_n [*4]);
endmodule : amrt_read_ctrl_monitor
bind amrt_read_ctrl amrt_read_ctrl_monitor amrt_read_ctrl_monitor_i (.clk, .arst_n,
  .flash_cs_assign, .cfg_load, .req_valid, .req_addr, .write_strobe_n, .req_ready,
  .rd_valid, .ext_addr, .ext_data_oe, .chip_select_n, .read_strobe_n,
  .flash_out_enable_n, .flash_write_enable_n, .read_mode_status, .busy);

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [23:0] rs_s = '0, cs_s = '0, ext_addr;
  logic [27:0] rs_p = '0, cs_p = '0;
  logic [35:0] cyc = '0;
  logic [3:0] mode = '0, asg = '0, chip_select_n, read_mode_status;
  logic cfg_load = 1'b0, req_valid = 1'b0, wr_n = 1'b1;
  logic req_ready, rd_valid, read_strobe_n, busy;
  logic foe_n, fwe_n, data_oe;
  logic [25:0] req_addr = '0;
  logic [7:0] rd_data, din;
  logic [31:0] r = 32'h0000_720b;
  int fail_count = 0, checks_done = 0;
  always #25 clk = ~clk;
  always @(posedge clk) wr_n <= ~wr_n;
  amrt_read_ctrl amrt_read_ctrl_i (.clk, .arst_n, .read_strobe_setup(rs_s),
    .select_read_setup(cs_s), .read_strobe_pulse(rs_p), .select_read_pulse(cs_p),
    .read_total_cycle(cyc), .read_mode_cfg(mode), .flash_cs_assign(asg), .cfg_load, .req_valid,
    .req_addr, .req_ready, .rd_valid, .rd_data, .write_strobe_n(wr_n), .ext_addr,
    .ext_data_in(din), .ext_data_out(), .ext_data_oe(data_oe), .chip_select_n, .read_strobe_n,
    .flash_out_enable_n(foe_n), .flash_write_enable_n(fwe_n), .read_mode_status, .busy);
  amrt_mem_model amrt_mem_model_i (.clk, .ext_addr, .chip_select_n, .read_strobe_n,
    .ext_data_in(din));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic int se(logic [5:0] c); return 128 * c[5] + c[4:0]; endfunction : se
  function automatic int pe(logic [6:0] c); return 256 * c[6] + c[5:0]; endfunction : pe
  function automatic int ce(logic [8:0] c); return 256 * c[8:7] + c[6:0]; endfunction : ce
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // load one select's codes (if ld), then issue n reads, holding valid until each take
  task automatic go(logic [1:0] i, logic [23:0] a, int n, logic [5:0] ss, sc,
                    logic [6:0] ps, pc, logic [8:0] cy, logic md, as, ld);
    int lo = 0, cl = 0, bz = 0, rv = 0, tk = 0, fs = -1, fc = -1, fl = 0;
    logic rdy, pr = 1'b1;
    if (ld) begin
      @(posedge clk);
      rs_s[i*6 +: 6] <= ss;
      cs_s[i*6 +: 6] <= sc;
      rs_p[i*7 +: 7] <= ps;
      cs_p[i*7 +: 7] <= pc;
      cyc[i*9 +: 9] <= cy;
      mode[i] <= md;
      asg[i] <= as;
      cfg_load <= 1'b1;
      @(posedge clk);
      cfg_load <= 1'b0;
    end
    @(posedge clk);
    req_addr <= {i, a};
    req_valid <= 1'b1;
    for (int t = 0; t < 3000; t++) begin
      @(negedge clk);
      if (read_strobe_n === 1'b0 && fs < 0) fs = t;
      if (chip_select_n[i] === 1'b0 && fc < 0) fc = t;
      if (pr === 1'b1 && read_strobe_n === 1'b0) fl++;
      pr = read_strobe_n;
      lo += int'(read_strobe_n === 1'b0);
      cl += int'(chip_select_n[i] === 1'b0);
      bz += int'(busy === 1'b1);
      if (rd_valid === 1'b1) rv++;
      if (rd_valid === 1'b1) chk("rd_data", a[7:0] ^ a[15:8] ^ a[23:16], rd_data);
      chk("flash_oe_n", (as && busy === 1'b1) ? read_strobe_n : 1'b1, foe_n);
      chk("flash_we_n", (as && busy === 1'b1) ? wr_n : 1'b1, fwe_n);
      chk("data_oe", 1'b0, data_oe);
      // a capture on the last edge shows after busy drops, so count it first
      if (tk == n && busy !== 1'b1) break;
      rdy = req_ready;
      @(posedge clk);
      if (rdy === 1'b1 && tk < n) tk++;
      if (tk == n) req_valid <= 1'b0;
    end
    chk("ext_addr", a, ext_addr);
    chk("captures", n, rv);
    chk("strobe_low", n * pe(ps), lo);
    chk("select_low", n * pe(pc), cl);
    chk("strobe_falls", 1, fl);
    chk("setup_gap", se(ss) - se(sc), fs - fc);
    chk("busy_len", n * ce(cy), bz);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("mode_status", 4'hf, read_mode_status);
    go(2'h1, 24'h00_1234, 1, 6'h01, 6'h01, 7'h01, 7'h01, 9'h003, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 12; k++) begin
      r = lfsr(r);
      // pulse codes kept at one or more; A21/A22 vary with the random address
      go(r[1:0], r[25:2], 1, {3'h0, r[4:2]}, {3'h0, r[7:5]}, {4'h0, r[10:8]} + 7'h01,
         {4'h0, r[13:11]} + 7'h01, 9'h010 + r[17:16], r[18], r[19], 1'b1);
    end
    go(2'h2, 24'h20_0010, 2, 6'h00, 6'h00, 7'h02, 7'h02, 9'h002, 1'b1, 1'b1, 1'b1);
    go(2'h3, 24'h40_0abc, 1, 6'h01, 6'h20, 7'h01, 7'h40, 9'h101, 1'b0, 1'b1, 1'b1);
    go(2'h0, 24'hff_ffff, 1, 6'h20, 6'h00, 7'h41, 7'h01, 9'h181, 1'b1, 1'b0, 1'b1);
    complete_run();
  end
  initial begin
    repeat (10000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : tb
